/* File: rtl/pidx_map.svh */
`ifndef PIDX_MAP_SVH
`define PIDX_MAP_SVH
// Register byte offsets on the APB side.
`define PIDX_CTRL_OFF 8'h00
`define PIDX_P_ONE_OFF 8'h04
`define PIDX_I_ONE_OFF 8'h08
`define PIDX_D_ONE_OFF 8'h0c
`define PIDX_P_TWO_OFF 8'h10
`define PIDX_I_TWO_OFF 8'h14
`define PIDX_D_TWO_OFF 8'h18
`define PIDX_THR_OFF 8'h1c
`define PIDX_INIT_OFF 8'h20
`define PIDX_HOLD_OFF 8'h24
`define PIDX_STEP_OFF 8'h28
`define PIDX_LOSS_OFF 8'h2c
`define PIDX_STATUS_OFF 8'h30
`define PIDX_IRQ_STAT_OFF 8'h34
`define PIDX_IRQ_MASK_OFF 8'h38
// Control register field positions.
`define PIDX_CTRL_MODE_LSB 0
`define PIDX_CTRL_SEP_BIT 4
`define PIDX_CTRL_LIMSTOP_BIT 8
`define PIDX_CTRL_RUNSTOP_BIT 12
// Reset values; percentages in 0.01 % steps, gains in 0.1, times in 10 ms.
`define PIDX_KP_RESET 16'h00c8
`define PIDX_TI_RESET 16'h00c8
`define PIDX_TD_RESET 16'h0000
`define PIDX_LOWER_RESET 16'h07d0
`define PIDX_UPPER_RESET 16'h1f40
`define PIDX_STEP_RESET 16'h0064
// Scaling: full scale output, the gain giving full scale, integrator fraction bits, blend unity.
`define PIDX_FULL_SCALE 16'h2710
`define PIDX_KP_SCALE 32'sh3e8
`define PIDX_INTEG_FRAC 10
`define PIDX_INTEG_MAX 32'sh009c4000
`define PIDX_BLEND_ONE 9'h100
// Timing.
`define PIDX_CLK_FREQ_HZ 20000000
`define PIDX_UPDATE_PERIOD_MS 2
`define PIDX_TICK_CYCLES (`PIDX_UPDATE_PERIOD_MS * (`PIDX_CLK_FREQ_HZ / 1000))
`define PIDX_TIME_UNIT_MS 10
`define PIDX_LOSS_UNIT_MS 100
`define PIDX_UNIT_TICKS (`PIDX_TIME_UNIT_MS / `PIDX_UPDATE_PERIOD_MS)
`define PIDX_LOSS_TICKS (`PIDX_LOSS_UNIT_MS / `PIDX_UPDATE_PERIOD_MS)
`endif

/* File: rtl/pidx_pkg.sv */
package pidx_pkg;
    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN = 2'b10
    } pidx_state_e;

    typedef enum logic [1:0] {
        SW_NONE = 2'b00,
        SW_INPUT = 2'b01,
        SW_AUTO = 2'b10
    } pidx_switch_e;

    // Gain arrays hold proportional, integral time and differential time at indices 0, 1, 2.
    typedef struct packed {
        pidx_switch_e gain_switch_condition;
        logic [1:0] integral_property_select;
        logic run_while_stopped_select;
        logic [2:0][15:0] gain_one;
        logic [2:0][15:0] gain_two;
        logic [15:0] lower_switch_threshold;
        logic [15:0] upper_switch_threshold;
        logic [15:0] initial_output_value;
        logic [15:0] initial_hold_time;
        logic [15:0] forward_step_limit;
        logic [15:0] reverse_step_limit;
        logic [15:0] feedback_loss_level;
        logic [15:0] feedback_loss_time;
    } pidx_cfg_s;
endpackage

/* File: rtl/pidx_sync.sv */
`timescale 1ns/1ps
// Three-stage input synchroniser; a change counts once stages one and two agree.
module pidx_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;

    // Stage zero feeds only stage one, so a metastable value never reaches the filter.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else if (ce) begin
            stage <= {stage[1:0], pin};
            if (stage[1] == stage[2]) begin
                level <= stage[2];
            end
        end
    end
endmodule // pidx_sync

/* File: rtl/pidx_blend.sv */
`timescale 1ns/1ps
// Linear blend of one gain between set one and set two, frac in 1/256 steps.
module pidx_blend (
    input wire logic [15:0] set_one,
    input wire logic [15:0] set_two,
    input wire logic [8:0] frac,
    output logic [15:0] blended
);
    logic signed [26:0] span;
    logic signed [26:0] scaled;

    // Signed span, since set two may lie below set one.
    assign span = 27'(signed'({1'b0, set_two})) - 27'(signed'({1'b0, set_one}));
    assign scaled = span * 27'(signed'({1'b0, frac}));
    assign blended = 16'(27'(signed'({1'b0, set_one})) + (scaled >>> 8));
endmodule // pidx_blend

/* File: rtl/pidx_top.sv */
`timescale 1ns/1ps
`include "pidx_map.svh"
// What this block does
// - The second gain set acts exactly like the first, each from its own three values.
// - With switchover by input, set one acts while the switch input is off and set two while on.
// - In automatic mode set one acts while the absolute deviation is below the lower threshold.
// - In automatic mode set two acts while the absolute deviation is above the upper threshold.
// - In automatic mode a deviation between the thresholds blends the two sets linearly.
// - At start the output is held at the initial value for the hold time before the loop closes.
// - One output is made every 2 ms and its change from the last is clamped.
// - Rising and falling steps each have their own absolute limit.
// - With integral separation on, the integrator freezes while the pause input is on.
// - With integral separation off, the pause input is ignored.
// - With limit stop on, the integrator freezes while the output is at its limit.
// - Feedback below the loss level for longer than the loss time raises the loss fault.
// - A loss level of zero switches the loss check off.
// - On stop the regulator halts unless run while stopped is selected.
// - A proportional gain of 100.0 at full deviation gives a full scale output change.
module pidx_top #(
    parameter int TICK_CYCLES = `PIDX_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic drive_run,
    input wire logic gain_switch_input,
    input wire logic integral_pause_input,
    input wire logic [15:0] setpoint,
    input wire logic [15:0] feedback,
    output logic [15:0] regulator_output,
    output logic feedback_loss_fault,
    output logic irq
);
    localparam pidx_pkg::pidx_cfg_s CFG_RESET = '{
        gain_switch_condition: pidx_pkg::SW_NONE,
        integral_property_select: 2'h0,
        run_while_stopped_select: 1'b0,
        gain_one: {`PIDX_TD_RESET, `PIDX_TI_RESET, `PIDX_KP_RESET},
        gain_two: {`PIDX_TD_RESET, `PIDX_TI_RESET, `PIDX_KP_RESET},
        lower_switch_threshold: `PIDX_LOWER_RESET,
        upper_switch_threshold: `PIDX_UPPER_RESET,
        initial_output_value: 16'h0000,
        initial_hold_time: 16'h0000,
        forward_step_limit: `PIDX_STEP_RESET,
        reverse_step_limit: `PIDX_STEP_RESET,
        feedback_loss_level: 16'h0000,
        feedback_loss_time: 16'h0000
    };

    pidx_pkg::pidx_cfg_s cfg;
    pidx_pkg::pidx_cfg_s next_cfg;
    pidx_pkg::pidx_state_e state;
    pidx_pkg::pidx_state_e next_state;
    logic [2:0] pin_s;
    logic run_s;
    logic switch_s;
    logic pause_s;
    logic active;
    logic halt;
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic addr_ok;
    logic [31:0] ctrl_word;
    logic [31:0] rd_word;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] rd_clr;
    logic [2:0] events;
    logic [2:0] next_irq_stat;
    logic [31:0] tick_cnt;
    logic tick;
    logic run_tick;
    logic signed [16:0] err;
    logic signed [16:0] err_prev;
    logic [15:0] mag;
    logic [15:0] span;
    logic [8:0] auto_alpha;
    logic [8:0] alpha;
    logic [2:0][15:0] gain;
    logic [15:0] ti_eff;
    logic signed [31:0] p_term;
    logic signed [31:0] i_step;
    logic signed [31:0] d_term;
    logic signed [31:0] integ;
    logic signed [31:0] integ_sum;
    logic signed [31:0] next_integ;
    logic signed [31:0] raw;
    logic signed [31:0] delta;
    logic [15:0] limited;
    logic [15:0] stepped;
    logic at_limit;
    logic freeze_integ;
    logic step_up;
    logic step_dn;
    logic [23:0] hold_cnt;
    logic [23:0] hold_limit;
    logic [15:0] loss_cnt;
    logic [15:0] loss_limit;
    logic loss_low;
    logic loss_trip;

    // Terminal pins come from outside this clock, one synchroniser each.
    for (genvar p = 0; p < 3; p++) begin : g_pin
        pidx_sync u_sync (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .pin(p == 0 ? drive_run : (p == 1 ? gain_switch_input : integral_pause_input)),
            .level(pin_s[p])
        );
    end
    assign run_s = pin_s[0];
    assign switch_s = pin_s[1];
    assign pause_s = pin_s[2];
    assign active = run_s | cfg.run_while_stopped_select;
    assign halt = ~active | feedback_loss_fault;

    // Bus decode; read data is captured in the setup cycle so the answer leaves a flip-flop.
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable & pready;
    assign wr_en = access_ph & pwrite & ~pslverr;
    assign addr_ok = (paddr <= `PIDX_IRQ_MASK_OFF) && (paddr[1:0] == 2'h0);
    assign ctrl_word = (32'(cfg.gain_switch_condition) << `PIDX_CTRL_MODE_LSB)
        | (32'(cfg.integral_property_select[0]) << `PIDX_CTRL_SEP_BIT)
        | (32'(cfg.integral_property_select[1]) << `PIDX_CTRL_LIMSTOP_BIT)
        | (32'(cfg.run_while_stopped_select) << `PIDX_CTRL_RUNSTOP_BIT);
    assign rd_word = (paddr == `PIDX_CTRL_OFF) ? ctrl_word :
        (paddr == `PIDX_P_ONE_OFF) ? {16'h0000, cfg.gain_one[0]} :
        (paddr == `PIDX_I_ONE_OFF) ? {16'h0000, cfg.gain_one[1]} :
        (paddr == `PIDX_D_ONE_OFF) ? {16'h0000, cfg.gain_one[2]} :
        (paddr == `PIDX_P_TWO_OFF) ? {16'h0000, cfg.gain_two[0]} :
        (paddr == `PIDX_I_TWO_OFF) ? {16'h0000, cfg.gain_two[1]} :
        (paddr == `PIDX_D_TWO_OFF) ? {16'h0000, cfg.gain_two[2]} :
        (paddr == `PIDX_THR_OFF) ? {cfg.upper_switch_threshold, cfg.lower_switch_threshold} :
        (paddr == `PIDX_INIT_OFF) ? {16'h0000, cfg.initial_output_value} :
        (paddr == `PIDX_HOLD_OFF) ? {16'h0000, cfg.initial_hold_time} :
        (paddr == `PIDX_STEP_OFF) ? {cfg.reverse_step_limit, cfg.forward_step_limit} :
        (paddr == `PIDX_LOSS_OFF) ? {cfg.feedback_loss_time, cfg.feedback_loss_level} :
        (paddr == `PIDX_STATUS_OFF) ? {13'h0000, state, feedback_loss_fault, regulator_output} :
        (paddr == `PIDX_IRQ_STAT_OFF) ? {29'h00000000, irq_stat} :
        (paddr == `PIDX_IRQ_MASK_OFF) ? {29'h00000000, irq_mask} : 32'h00000000;

    // A status read clears only the bits it returned, so an event landing meanwhile survives.
    assign rd_clr = (access_ph && !pwrite && paddr == `PIDX_IRQ_STAT_OFF) ? prdata[2:0] : 3'h0;
    assign events = {run_tick & (step_up | step_dn), state == pidx_pkg::ST_HOLD && next_state == pidx_pkg::ST_RUN,
        loss_trip & ~feedback_loss_fault};
    assign next_irq_stat = (irq_stat & ~rd_clr) | events;

    // Register writes take effect at the access edge only.
    always_comb begin
        next_cfg = cfg;
        if (wr_en) begin
            case (paddr)
                `PIDX_CTRL_OFF: begin
                    next_cfg.gain_switch_condition = pidx_pkg::pidx_switch_e'(pwdata[`PIDX_CTRL_MODE_LSB +: 2]);
                    next_cfg.integral_property_select = {pwdata[`PIDX_CTRL_LIMSTOP_BIT], pwdata[`PIDX_CTRL_SEP_BIT]};
                    next_cfg.run_while_stopped_select = pwdata[`PIDX_CTRL_RUNSTOP_BIT];
                end
                `PIDX_P_ONE_OFF: next_cfg.gain_one[0] = pwdata[15:0];
                `PIDX_I_ONE_OFF: next_cfg.gain_one[1] = pwdata[15:0];
                `PIDX_D_ONE_OFF: next_cfg.gain_one[2] = pwdata[15:0];
                `PIDX_P_TWO_OFF: next_cfg.gain_two[0] = pwdata[15:0];
                `PIDX_I_TWO_OFF: next_cfg.gain_two[1] = pwdata[15:0];
                `PIDX_D_TWO_OFF: next_cfg.gain_two[2] = pwdata[15:0];
                `PIDX_THR_OFF: {next_cfg.upper_switch_threshold, next_cfg.lower_switch_threshold} = pwdata;
                `PIDX_INIT_OFF: next_cfg.initial_output_value = pwdata[15:0];
                `PIDX_HOLD_OFF: next_cfg.initial_hold_time = pwdata[15:0];
                `PIDX_STEP_OFF: {next_cfg.reverse_step_limit, next_cfg.forward_step_limit} = pwdata;
                `PIDX_LOSS_OFF: {next_cfg.feedback_loss_time, next_cfg.feedback_loss_level} = pwdata;
                default: ;
            endcase
        end
    end

    // Bus slave, configuration and interrupt state.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg <= CFG_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            irq <= 1'b0;
        end else if (ce) begin
            cfg <= next_cfg;
            pready <= setup_ph;
            if (setup_ph) begin
                prdata <= addr_ok ? rd_word : 32'h00000000;
                pslverr <= ~addr_ok;
            end
            if (wr_en && paddr == `PIDX_IRQ_MASK_OFF) begin
                irq_mask <= pwdata[2:0];
            end
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    // The 2 ms update strobe runs free so outputs stay on a fixed grid.
    assign tick = ce && (tick_cnt == 32'(TICK_CYCLES - 1));
    assign run_tick = tick && state == pidx_pkg::ST_RUN && next_state == pidx_pkg::ST_RUN;

    // Switchover first: both sets feed the same blend and arithmetic path.
    assign err = 17'(signed'({1'b0, setpoint})) - 17'(signed'({1'b0, feedback}));
    assign mag = err[16] ? 16'(-err) : err[15:0];
    assign span = cfg.upper_switch_threshold - cfg.lower_switch_threshold;
    assign auto_alpha = (mag < cfg.lower_switch_threshold) ? 9'h000 :
        (mag > cfg.upper_switch_threshold || span == 16'h0000) ? `PIDX_BLEND_ONE :
        9'(({8'h00, mag - cfg.lower_switch_threshold} << 8) / {8'h00, span});
    assign alpha = (cfg.gain_switch_condition == pidx_pkg::SW_INPUT) ? (switch_s ? `PIDX_BLEND_ONE : 9'h000) :
        (cfg.gain_switch_condition == pidx_pkg::SW_AUTO) ? auto_alpha : 9'h000;
    for (genvar g = 0; g < 3; g++) begin : g_gain
        pidx_blend u_blend (
            .set_one(cfg.gain_one[g]),
            .set_two(cfg.gain_two[g]),
            .frac(alpha),
            .blended(gain[g])
        );
    end

    // Regulator arithmetic; a zero integral time is taken as the smallest step to avoid dividing by zero.
    assign ti_eff = (gain[1] == 16'h0000) ? 16'h0001 : gain[1];
    assign p_term = (32'(signed'({1'b0, gain[0]})) * 32'(err)) / `PIDX_KP_SCALE;
    assign i_step = (32'(err) <<< `PIDX_INTEG_FRAC) / (32'(signed'({1'b0, ti_eff})) * 32'(`PIDX_UNIT_TICKS));
    assign d_term = (32'(signed'({1'b0, gain[2]})) * 32'(err - err_prev)) / 32'(`PIDX_UPDATE_PERIOD_MS);
    assign raw = p_term + (integ >>> `PIDX_INTEG_FRAC) + d_term;
    assign at_limit = (raw <= 32'sh0) || (raw >= 32'(`PIDX_FULL_SCALE));
    assign limited = (raw <= 32'sh0) ? 16'h0000 : (raw >= 32'(`PIDX_FULL_SCALE)) ? `PIDX_FULL_SCALE : raw[15:0];

    // Integral pause is evaluated next; the pause input matters only with separation on.
    assign freeze_integ = (cfg.integral_property_select[0] & pause_s)
        | (cfg.integral_property_select[1] & at_limit);
    assign integ_sum = integ + i_step;
    assign next_integ = freeze_integ ? integ :
        (integ_sum > `PIDX_INTEG_MAX) ? `PIDX_INTEG_MAX :
        (integ_sum < -`PIDX_INTEG_MAX) ? -`PIDX_INTEG_MAX : integ_sum;

    // Step limit then: each direction clamps against its own absolute limit.
    assign delta = 32'(signed'({1'b0, limited})) - 32'(signed'({1'b0, regulator_output}));
    assign step_up = delta > 32'(signed'({1'b0, cfg.forward_step_limit}));
    assign step_dn = -delta > 32'(signed'({1'b0, cfg.reverse_step_limit}));
    assign stepped = step_up ? regulator_output + cfg.forward_step_limit :
        step_dn ? regulator_output - cfg.reverse_step_limit : limited;

    // Loss timer last; a zero level never counts.
    assign loss_low = (cfg.feedback_loss_level != 16'h0000) && (feedback < cfg.feedback_loss_level);
    assign loss_limit = 16'(cfg.feedback_loss_time * 16'(`PIDX_LOSS_TICKS));
    assign loss_trip = tick && state != pidx_pkg::ST_STOP && loss_low && loss_cnt > loss_limit;
    assign hold_limit = 24'(cfg.initial_hold_time) * 24'(`PIDX_UNIT_TICKS);

    // Start, hold and run sequencing.
    always_comb begin
        next_state = state;
        unique case (state)
            pidx_pkg::ST_STOP: begin
                if (active && !feedback_loss_fault) begin
                    next_state = pidx_pkg::ST_HOLD;
                end
            end
            pidx_pkg::ST_HOLD: begin
                if (halt) begin
                    next_state = pidx_pkg::ST_STOP;
                end else if (tick && hold_cnt >= hold_limit) begin
                    next_state = pidx_pkg::ST_RUN;
                end
            end
            pidx_pkg::ST_RUN: begin
                if (halt) begin
                    next_state = pidx_pkg::ST_STOP;
                end
            end
            default: next_state = pidx_pkg::ST_STOP;
        endcase
    end

    // Output, integrator and hold counter.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= pidx_pkg::ST_STOP;
            tick_cnt <= 32'h0;
            regulator_output <= 16'h0000;
            integ <= 32'sh0;
            err_prev <= 17'sh0;
            hold_cnt <= 24'h0;
        end else if (ce) begin
            state <= next_state;
            tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
            if (next_state == pidx_pkg::ST_STOP) begin
                regulator_output <= 16'h0000;
                integ <= 32'sh0;
                hold_cnt <= 24'h0;
            end else if (next_state == pidx_pkg::ST_HOLD) begin
                regulator_output <= cfg.initial_output_value;
                err_prev <= err;
                hold_cnt <= (state == pidx_pkg::ST_HOLD && tick) ? hold_cnt + 24'h1 : hold_cnt;
            end else if (run_tick) begin
                regulator_output <= stepped;
                integ <= next_integ;
                err_prev <= err;
            end
        end
    end

    // Loss counter and fault; a trip in the cycle the drive stops still sets the fault.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            loss_cnt <= 16'h0000;
            feedback_loss_fault <= 1'b0;
        end else if (ce) begin
            if (state == pidx_pkg::ST_STOP || (tick && !loss_low)) begin
                loss_cnt <= 16'h0000;
            end else if (tick && loss_cnt != 16'hffff) begin
                loss_cnt <= loss_cnt + 16'h0001;
            end
            if (loss_trip) begin
                feedback_loss_fault <= 1'b1;
            end else if (!active) begin
                feedback_loss_fault <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_start;
        state == pidx_pkg::ST_STOP ##1 state == pidx_pkg::ST_HOLD;
    endsequence

    a_input_gain_pick: assert property (
        cfg.gain_switch_condition == pidx_pkg::SW_INPUT |->
        gain[0] == (switch_s ? cfg.gain_two[0] : cfg.gain_one[0]))
        else $error("Gain does not follow the switch input.");
    a_auto_low_set: assert property (
        cfg.gain_switch_condition == pidx_pkg::SW_AUTO && mag < cfg.lower_switch_threshold |->
        gain == cfg.gain_one)
        else $error("Low deviation did not pick set one.");
    a_auto_high_set: assert property (
        cfg.gain_switch_condition == pidx_pkg::SW_AUTO && mag > cfg.upper_switch_threshold |->
        gain == cfg.gain_two)
        else $error("High deviation did not pick set two.");
    a_hold_initial_value: assert property (
        s_start |-> regulator_output == $past(cfg.initial_output_value))
        else $error("Start did not load the initial value.");
    a_update_period: assert property (
        state == pidx_pkg::ST_RUN && next_state == pidx_pkg::ST_RUN && !tick |=> $stable(regulator_output))
        else $error("Output moved between updates.");
    a_step_clamp_both: assert property (
        run_tick |=> 17'(regulator_output) <= 17'($past(regulator_output)) + 17'($past(cfg.forward_step_limit))
        && 17'(regulator_output) + 17'($past(cfg.reverse_step_limit)) >= 17'($past(regulator_output)))
        else $error("Output step beyond its limit.");
    a_pause_freeze: assert property (
        run_tick && cfg.integral_property_select[0] && pause_s |=> $stable(integ))
        else $error("Integrator moved during pause.");
    a_limit_freeze: assert property (
        run_tick && cfg.integral_property_select[1] && at_limit |=> $stable(integ))
        else $error("Integrator moved at the limit.");
    a_loss_timing: assert property (
        $rose(feedback_loss_fault) |-> $past(loss_cnt) > $past(loss_limit) && $past(loss_low))
        else $error("Loss fault raised too early.");
    a_loss_disabled: assert property (
        cfg.feedback_loss_level == 16'h0000 && !feedback_loss_fault |=> !feedback_loss_fault)
        else $error("Loss fault raised with check off.");
    a_stop_halts: assert property (
        ce && !active |=> state == pidx_pkg::ST_STOP && regulator_output == 16'h0000)
        else $error("Regulator kept running on stop.");
endmodule // pidx_top

/* File: bench/pidx_field_model.sv */
`timescale 1ns/1ps
// Terminals and process side: bench requests reach the pins one edge later.
module pidx_field_model (
    input wire logic clk_sys,
    input wire logic run_req,
    input wire logic sw_req,
    input wire logic pause_req,
    input wire logic [15:0] sp_req,
    input wire logic [15:0] fb_req,
    output logic drive_run,
    output logic gain_switch_input,
    output logic integral_pause_input,
    output logic [15:0] setpoint,
    output logic [15:0] feedback
);
    // Registered so pins never move in the same step as the design samples.
    always_ff @(posedge clk_sys) begin
        drive_run <= run_req;
        gain_switch_input <= sw_req;
        integral_pause_input <= pause_req;
        setpoint <= sp_req;
        feedback <= fb_req;
    end
endmodule // pidx_field_model

/* File: bench/pidx_top_tb.sv */
`timescale 1ns/1ps
`include "pidx_map.svh"
module pidx_top_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, irq, fault, run, sw, pause;
    logic run_req = 1'b0;
    logic sw_req = 1'b0;
    logic pause_req = 1'b0;
    logic [15:0] sp_req = 16'h0;
    logic [15:0] out, sp, fb, prev;
    int n_fail = 0;
    int checks = 0;
    int i;
    pidx_field_model i_pidx_field_model (.clk_sys(clk_sys), .run_req(run_req), .sw_req(sw_req),
        .pause_req(pause_req), .sp_req(sp_req), .fb_req(16'h0), .drive_run(run), .gain_switch_input(sw),
        .integral_pause_input(pause), .setpoint(sp), .feedback(fb));
    pidx_top #(.TICK_CYCLES(20)) i_pidx_top (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drive_run(run), .gain_switch_input(sw),
        .integral_pause_input(pause), .setpoint(sp), .feedback(fb), .regulator_output(out),
        .feedback_loss_fault(fault), .irq(irq));
    // Free-running 20 MHz clock.
    always #25 clk_sys = ~clk_sys;
    task stop_test;
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; a missing pready ends the run rather than hanging.
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk_sys);
        if (i == 20) begin
            n_fail++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for the next change of the regulator output, bounded.
    task wchg;
        prev = out;
        for (i = 0; i < 400 && out === prev; i++) @(posedge clk_sys);
        if (i == 400) begin
            n_fail++;
            stop_test();
        end
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        acc(0, `PIDX_P_ONE_OFF, 0);
        chk(rd, 32'h00c8);
        acc(0, `PIDX_STEP_OFF, 0);
        chk(rd, 32'h0064_0064);
        acc(0, `PIDX_THR_OFF, 0);
        chk(rd, 32'h1f40_07d0);
        acc(0, 8'h3c, 0);
        chk({31'h0, err}, 32'h1);
        acc(1, `PIDX_INIT_OFF, 32'h1388);
        acc(1, `PIDX_HOLD_OFF, 32'h1);
        acc(1, `PIDX_STEP_OFF, 32'h0032_0064);
        acc(1, `PIDX_IRQ_MASK_OFF, 32'h6);
        sp_req <= 16'h2710;
        run_req <= 1'b1;
        repeat (60) @(posedge clk_sys);
        acc(0, `PIDX_STATUS_OFF, 0);
        chk(rd, 32'h0002_1388);
        wchg();
        chk({16'h0, out}, 32'h1356);
        acc(1, `PIDX_P_ONE_OFF, 32'h03e8);
        repeat (25) @(posedge clk_sys);
        wchg();
        chk({16'h0, out - prev}, 32'h64);
        chk({31'h0, irq}, 32'h1);
        acc(1, `PIDX_IRQ_MASK_OFF, 32'h0);
        acc(0, `PIDX_IRQ_STAT_OFF, 0);
        chk(rd, 32'h6);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, fault}, 32'h0);
        acc(1, `PIDX_LOSS_OFF, 32'h0000_1388);
        for (i = 0; i < 100 && fault !== 1'b1; i++) @(posedge clk_sys);
        chk({31'h0, fault}, 32'h1);
        repeat (5) @(posedge clk_sys);
        chk({16'h0, out}, 32'h0);
        run_req <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk({15'h0, fault, out}, 32'h0);
        // Run while stopped, switch input picks set two, pause holds the integrator at zero.
        sw_req <= 1'b1;
        pause_req <= 1'b1;
        acc(1, `PIDX_LOSS_OFF, 32'h0);
        acc(1, `PIDX_HOLD_OFF, 32'h0);
        acc(1, `PIDX_STEP_OFF, 32'h2710_2710);
        acc(1, `PIDX_P_TWO_OFF, 32'h0064);
        acc(1, `PIDX_CTRL_OFF, 32'h1011);
        repeat (3) @(posedge clk_sys);
        wchg();
        chk({16'h0, out}, 32'h03e8);
        repeat (25) @(posedge clk_sys);
        chk({16'h0, out}, 32'h03e8);
        sw_req <= 1'b0;
        wchg();
        chk({16'h0, out}, 32'h2710);
        // Automatic mode: middle, high and low deviation.
        sp_req <= 16'h1388;
        acc(1, `PIDX_CTRL_OFF, 32'h1012);
        wchg();
        chk({16'h0, out}, 32'h0abe);
        sp_req <= 16'h2710;
        wchg();
        chk({16'h0, out}, 32'h03e8);
        sp_req <= 16'h0640;
        wchg();
        chk({16'h0, out}, 32'h0640);
        // Separation off: the pause input no longer stops the integrator.
        acc(1, `PIDX_CTRL_OFF, 32'h1000);
        wchg();
        chk({16'h0, out}, 32'h0641);
        sp_req <= 16'h2710;
        acc(1, `PIDX_CTRL_OFF, 32'h1100);
        wchg();
        chk({16'h0, out}, 32'h2710);
        stop_test();
    end
endmodule // pidx_top_tb
